// ---- rtl/dpc_pkg.sv ----
// Package: register map, field positions and reset values of the dual counter block
`default_nettype none
package dpc_pkg;
  localparam logic [7:0] CTRL0_OFS = 8'h00;
  localparam logic [7:0] CTRL1_OFS = 8'h04;
  localparam logic [7:0] LOAD0_OFS = 8'h08;
  localparam logic [7:0] LOAD1_OFS = 8'h0c;
  localparam logic [7:0] PRE0_OFS = 8'h10;
  localparam logic [7:0] PRE1_OFS = 8'h14;
  localparam logic [7:0] CNT0_OFS = 8'h18;
  localparam logic [7:0] CNT1_OFS = 8'h1c;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h20;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h24;
  localparam logic [7:0] PINCFG_OFS = 8'h28;
  // Control register: write-one command bits, the mode bit and the read-only run bit
  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT = 1;
  localparam int CMD_CONT_BIT = 2;
  localparam int CMD_RELOAD_BIT = 3;
  localparam int MODE_CONT_BIT = 4;
  localparam int RUN_BIT = 5;
  // Pin configuration bits
  localparam int EXT_SEL_BIT = 0;
  localparam int EXT_EN_BIT = 1;
  localparam int OUT_EN_BIT = 2;
  localparam int OUT_SRC_BIT = 3;
  localparam logic [7:0] LOAD_RST = 8'h00;
  localparam logic [5:0] PRE_RST = 6'h00;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ---- rtl/dpc_channel.sv ----
// One prescaler and down-counter channel
`timescale 1ns/1ps
`default_nettype none
module dpc_channel (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic tick, // Selected source pulse
  input wire logic [7:0] load_val, // Initial count, 0 means 256
  input wire logic [5:0] pre_val, // Prescale ratio minus one
  input wire logic mode_cont, // Continuous reload mode
  input wire logic cmd_start, // Start from the initial value
  input wire logic cmd_stop, // Stop counting
  input wire logic cmd_cont, // Resume from current count
  input wire logic cmd_reload, // Reload initial value, keep state
  output logic running, // Counter enabled
  output logic [7:0] count, // Current count
  output logic eoc // One-cycle end of count pulse
);
  logic [5:0] pre_cnt;
  logic pre_end;

  assign pre_end = running && tick && (pre_cnt == 6'h00);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_cnt <= 6'h00;
    end else if (cmd_start || cmd_reload) begin
      pre_cnt <= pre_val;
    end else if (running && tick) begin
      pre_cnt <= (pre_cnt == 6'h00) ? pre_val : pre_cnt - 6'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      running <= 1'b0;
    end else if (cmd_stop) begin
      running <= 1'b0;
    end else if (cmd_start || cmd_cont) begin
      running <= 1'b1;
    end else if (pre_end && count == 8'h01 && !mode_cont) begin
      running <= 1'b0;
    end
  end

  // Load value 0 stands for 256, so count 0 is a legal running state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= 8'h00;
    end else if (cmd_start || cmd_reload) begin
      count <= load_val;
    end else if (pre_end) begin
      if (count == 8'h01) begin
        count <= mode_cont ? load_val : 8'h00;
      end else begin
        count <= count - 8'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eoc <= 1'b0;
    end else begin
      eoc <= pre_end && (count == 8'h01);
    end
  end
endmodule
`default_nettype wire

// ---- rtl/dpc_top.sv ----
// Dual prescaled down-counter block with AXI4-Lite register access
// Functional notes
// - Two independent 8-bit down-counters, each behind its own 6-bit prescaler.
// - Second prescaler uses internal clock or external input; first uses internal only.
// - Each prescaler divides its source by any ratio from 1 to 64.
// - Counter decrements per prescaler pulse from an initial count of 1 to 256.
// - Counter and prescaler both ending raise that counter's timer request.
// - Commands: start, stop, continue from current count, reload initial value without changing run state.
// - Single-pass mode stops at zero; continuous mode reloads and keeps counting.
// - Software may route port pins as external count input and counter output.
`timescale 1ns/1ps
`default_nettype none
module dpc_top (
  input wire logic aclk, // System clock, 10 MHz
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic external_count_input, // Port pin, asynchronous
  output logic counter_output_pin, // Toggling counter output
  output logic first_timer_request, // Level, first counter event
  output logic second_timer_request, // Level, second counter event
  output logic irq // Level, any unmasked status bit
);
  logic [7:0] load0, load1;
  logic [5:0] pre0, pre1;
  logic mode0, mode1;
  logic [3:0] pincfg;
  logic [1:0] irq_stat, irq_mask;
  logic [3:0] cmd0, cmd1;
  logic run0, run1, eoc0, eoc1;
  logic [7:0] count0, count1;
  logic ext_s1, ext_s2, ext_d;
  logic ext_tick, tick1;
  logic aw_hold, w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write, do_read;
  logic [7:0] rd_addr;

  function automatic logic [31:0] ctrl_word(input logic mode, input logic run);
    ctrl_word = 32'h0000_0000;
    ctrl_word[dpc_pkg::MODE_CONT_BIT] = mode;
    ctrl_word[dpc_pkg::RUN_BIT] = run;
  endfunction

  // Synchroniser; first stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_d <= 1'b0;
    end else begin
      ext_s1 <= external_count_input;
      ext_s2 <= ext_s1;
      ext_d <= ext_s2;
    end
  end

  assign ext_tick = pincfg[dpc_pkg::EXT_EN_BIT] && ext_s2 && !ext_d;
  assign tick1 = pincfg[dpc_pkg::EXT_SEL_BIT] ? ext_tick : 1'b1;

  // AXI write channel: address and data taken independently
  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready = !w_hold && !s_axi_bvalid;
  assign do_write = aw_hold && w_hold && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_hold <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_hold <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dpc_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr[7:2] > dpc_pkg::PINCFG_OFS[7:2] || aw_addr[7:2] ==
                      dpc_pkg::CNT0_OFS[7:2] || aw_addr[7:2] == dpc_pkg::CNT1_OFS[7:2])
                     ? dpc_pkg::RESP_SLVERR : dpc_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Byte lane 0 carries every field; command bits are one-cycle pulses
  always_comb begin
    cmd0 = 4'h0;
    cmd1 = 4'h0;
    if (do_write && w_strb[0]) begin
      if ({aw_addr[7:2], 2'b00} == dpc_pkg::CTRL0_OFS) begin
        cmd0 = w_data[dpc_pkg::CMD_RELOAD_BIT:dpc_pkg::CMD_START_BIT];
      end
      if ({aw_addr[7:2], 2'b00} == dpc_pkg::CTRL1_OFS) begin
        cmd1 = w_data[dpc_pkg::CMD_RELOAD_BIT:dpc_pkg::CMD_START_BIT];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load0 <= dpc_pkg::LOAD_RST;
      load1 <= dpc_pkg::LOAD_RST;
      pre0 <= dpc_pkg::PRE_RST;
      pre1 <= dpc_pkg::PRE_RST;
      mode0 <= 1'b0;
      mode1 <= 1'b0;
      irq_mask <= dpc_pkg::MASK_RST;
      pincfg <= 4'h0;
    end else if (do_write && w_strb[0]) begin
      case ({aw_addr[7:2], 2'b00})
        dpc_pkg::CTRL0_OFS: mode0 <= w_data[dpc_pkg::MODE_CONT_BIT];
        dpc_pkg::CTRL1_OFS: mode1 <= w_data[dpc_pkg::MODE_CONT_BIT];
        dpc_pkg::LOAD0_OFS: load0 <= w_data[7:0];
        dpc_pkg::LOAD1_OFS: load1 <= w_data[7:0];
        dpc_pkg::PRE0_OFS: pre0 <= w_data[5:0];
        dpc_pkg::PRE1_OFS: pre1 <= w_data[5:0];
        dpc_pkg::IRQ_MASK_OFS: irq_mask <= w_data[1:0];
        dpc_pkg::PINCFG_OFS: pincfg <= w_data[3:0];
        default: begin
        end
      endcase
    end
  end

  dpc_channel u_ch0 (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(1'b1),
    .load_val(load0),
    .pre_val(pre0),
    .mode_cont(mode0),
    .cmd_start(cmd0[0]),
    .cmd_stop(cmd0[1]),
    .cmd_cont(cmd0[2]),
    .cmd_reload(cmd0[3]),
    .running(run0),
    .count(count0),
    .eoc(eoc0)
  );

  dpc_channel u_ch1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick1),
    .load_val(load1),
    .pre_val(pre1),
    .mode_cont(mode1),
    .cmd_start(cmd1[0]),
    .cmd_stop(cmd1[1]),
    .cmd_cont(cmd1[2]),
    .cmd_reload(cmd1[3]),
    .running(run1),
    .count(count1),
    .eoc(eoc1)
  );

  // AXI read channel, one cycle from address to data
  assign s_axi_arready = !s_axi_rvalid;
  assign do_read = s_axi_arvalid && s_axi_arready;
  assign rd_addr = {s_axi_araddr[7:2], 2'b00};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= dpc_pkg::RESP_OKAY;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= dpc_pkg::RESP_OKAY;
      case (rd_addr)
        dpc_pkg::CTRL0_OFS: s_axi_rdata <= ctrl_word(mode0, run0);
        dpc_pkg::CTRL1_OFS: s_axi_rdata <= ctrl_word(mode1, run1);
        dpc_pkg::LOAD0_OFS: s_axi_rdata <= {24'h000000, load0};
        dpc_pkg::LOAD1_OFS: s_axi_rdata <= {24'h000000, load1};
        dpc_pkg::PRE0_OFS: s_axi_rdata <= {26'h0000000, pre0};
        dpc_pkg::PRE1_OFS: s_axi_rdata <= {26'h0000000, pre1};
        dpc_pkg::CNT0_OFS: s_axi_rdata <= {24'h000000, count0};
        dpc_pkg::CNT1_OFS: s_axi_rdata <= {24'h000000, count1};
        dpc_pkg::IRQ_STAT_OFS: s_axi_rdata <= {30'h00000000, irq_stat};
        dpc_pkg::IRQ_MASK_OFS: s_axi_rdata <= {30'h00000000, irq_mask};
        dpc_pkg::PINCFG_OFS: s_axi_rdata <= {28'h0000000, pincfg};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= dpc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Sticky status; a new event in the clearing read's cycle survives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= 2'h0;
    end else begin
      irq_stat <= ((do_read && rd_addr == dpc_pkg::IRQ_STAT_OFS) ? 2'h0 : irq_stat)
                  | {eoc1, eoc0};
    end
  end

  assign first_timer_request = irq_stat[0];
  assign second_timer_request = irq_stat[1];
  assign irq = |(irq_stat & irq_mask);

  // Output pin toggles at each end of count of the chosen counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      counter_output_pin <= 1'b0;
    end else if (!pincfg[dpc_pkg::OUT_EN_BIT]) begin
      counter_output_pin <= 1'b0;
    end else if (pincfg[dpc_pkg::OUT_SRC_BIT] ? eoc1 : eoc0) begin
      counter_output_pin <= !counter_output_pin;
    end
  end
endmodule
`default_nettype wire

// ---- tb/dpc_top_sva.sv ----
// Checker for the register bus handshakes and the timer request outputs
`timescale 1ns/1ps
`default_nettype none
module dpc_top_sva (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic s_axi_awvalid, // Write address valid
  input wire logic s_axi_awready, // Write address ready
  input wire logic s_axi_wvalid, // Write data valid
  input wire logic s_axi_wready, // Write data ready
  input wire logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic [31:0] s_axi_rdata, // Read data
  input wire logic [1:0] s_axi_rresp, // Read response
  input wire logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic first_timer_request, // First counter request
  input wire logic second_timer_request, // Second counter request
  input wire logic irq // Combined interrupt
);
  // Status read taken on the bus; only such a read may clear a request
  logic stat_rd;
  assign stat_rd = s_axi_arvalid && s_axi_arready
                   && {s_axi_araddr[7:2], 2'b00} == dpc_pkg::IRQ_STAT_OFS;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  wr_answer_a: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write answer missing");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read answer late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer not held");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  bad_read_a: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr[7:2] > dpc_pkg::PINCFG_OFS[7:2] |=>
    s_axi_rresp == dpc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  req0_sticky_a: assert property ($fell(first_timer_request) |-> $past(stat_rd, 1))
    else $error("first request cleared without status read");
  req1_sticky_a: assert property ($fell(second_timer_request) |-> $past(stat_rd, 1))
    else $error("second request cleared without status read");
  irq_cause_a: assert property (irq |-> first_timer_request || second_timer_request)
    else $error("interrupt without request");
endmodule
bind dpc_top dpc_top_sva u_dpc_top_sva (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .first_timer_request, .second_timer_request, .irq);
`default_nettype wire

// ---- tb/dpc_pin_src.sv ----
// External count input source standing at the port pin
`timescale 1ns/1ps
`default_nettype none
module dpc_pin_src (
  input wire logic aclk, // System clock
  output logic pin // External count input level
);
  initial pin = 1'b0;
  // Three cycles high, three low: wider than the minimum pulse and period
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge aclk);
      pin <= 1'b1;
      repeat (3) @(posedge aclk);
      pin <= 1'b0;
      repeat (2) @(posedge aclk);
    end
  endtask
endmodule
`default_nettype wire

// ---- tb/dpc_top_tb.sv ----
// Self-checking bench for the dual prescaled down-counter block
`timescale 1ns/1ps
`default_nettype none
module dpc_top_tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, p;
  logic external_count_input, counter_output_pin, first_timer_request, second_timer_request, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int n_errors, n_compared, n, k;
  int tbl [3][3] = '{'{5, 3, 20}, '{2, 63, 128}, '{0, 0, 256}};
  dpc_top u_dpc_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .external_count_input, .counter_output_pin, .first_timer_request,
    .second_timer_request, .irq);
  dpc_pin_src u_dpc_pin_src (.aclk, .pin(external_count_input));
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic guard(input int i, input int lim);
    if (i >= lim) begin
      n_errors++;
      $display("CHECK FAILED at %0t: wait timed out", $time);
      end_of_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    logic ta, tw;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 200; i++) begin
      @(negedge aclk);
      if (s_axi_bvalid && !s_axi_awvalid && !s_axi_wvalid) break;
      ta = s_axi_awready;
      tw = s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    guard(i, 200);
    check(32'(s_axi_bresp), 32'(er));
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int i;
    logic ta;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 200; i++) begin
      @(negedge aclk);
      if (s_axi_rvalid && !s_axi_arvalid) break;
      ta = s_axi_arready;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    guard(i, 200);
    check(s_axi_rdata, ed);
    check(32'(s_axi_rresp), 32'(er));
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  // Cycles until the selected request is seen high
  task automatic wait_req(input logic sel, output int c);
    for (c = 0; c < 20000; c++) begin
      @(negedge aclk);
      if ((sel ? second_timer_request : first_timer_request) === 1'b1) break;
    end
    guard(c, 20000);
  endtask
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(dpc_pkg::LOAD0_OFS, 32'h0, dpc_pkg::RESP_OKAY);
    rd(dpc_pkg::IRQ_MASK_OFS, 32'h0, dpc_pkg::RESP_OKAY);
    rd(8'h2c, 32'h0, dpc_pkg::RESP_SLVERR);
    wr(dpc_pkg::CNT0_OFS, 32'h5, dpc_pkg::RESP_SLVERR);
    check(32'(counter_output_pin), 32'h0);
    $display("test reset done");
    for (k = 0; k < 3; k++) begin
      wr(dpc_pkg::LOAD0_OFS, 32'(tbl[k][0]), dpc_pkg::RESP_OKAY);
      wr(dpc_pkg::PRE0_OFS, 32'(tbl[k][1]), dpc_pkg::RESP_OKAY);
      wr(dpc_pkg::CTRL0_OFS, 32'h1, dpc_pkg::RESP_OKAY);
      wait_req(1'b0, n);
      check(32'(n >= tbl[k][2] - 3 && n <= tbl[k][2] + 2), 32'h1);
      rd(dpc_pkg::IRQ_STAT_OFS, 32'h1, dpc_pkg::RESP_OKAY);
      check(32'(first_timer_request), 32'h0);
      rd(dpc_pkg::CNT0_OFS, 32'h0, dpc_pkg::RESP_OKAY);
      rd(dpc_pkg::CTRL0_OFS, 32'h0, dpc_pkg::RESP_OKAY);
    end
    $display("test single pass done");
    wr(dpc_pkg::IRQ_MASK_OFS, 32'h1, dpc_pkg::RESP_OKAY);
    wr(dpc_pkg::LOAD0_OFS, 32'h4, dpc_pkg::RESP_OKAY);
    wr(dpc_pkg::PRE0_OFS, 32'h0, dpc_pkg::RESP_OKAY);
    wr(dpc_pkg::CTRL0_OFS, 32'h11, dpc_pkg::RESP_OKAY);
    wait_req(1'b0, n);
    check(32'(irq), 32'h1);
    rd(dpc_pkg::IRQ_STAT_OFS, 32'h1, dpc_pkg::RESP_OKAY);
    wait_req(1'b0, n);
    check(32'(n <= 4), 32'h1);
    rd(dpc_pkg::CTRL0_OFS, 32'h30, dpc_pkg::RESP_OKAY);
    wr(dpc_pkg::CTRL0_OFS, 32'h12, dpc_pkg::RESP_OKAY);
    rd(dpc_pkg::CTRL0_OFS, 32'h10, dpc_pkg::RESP_OKAY);
    wr(dpc_pkg::CTRL0_OFS, 32'h14, dpc_pkg::RESP_OKAY);
    rd(dpc_pkg::CTRL0_OFS, 32'h30, dpc_pkg::RESP_OKAY);
    wr(dpc_pkg::CTRL0_OFS, 32'h12, dpc_pkg::RESP_OKAY);
    wr(dpc_pkg::CTRL0_OFS, 32'h18, dpc_pkg::RESP_OKAY);
    rd(dpc_pkg::CNT0_OFS, 32'h4, dpc_pkg::RESP_OKAY);
    rd(dpc_pkg::CNT0_OFS, 32'h4, dpc_pkg::RESP_OKAY);
    rd(dpc_pkg::IRQ_STAT_OFS, 32'h1, dpc_pkg::RESP_OKAY);
    // Lane 0 strobe low: the load value must not move
    s_axi_wstrb <= 4'he;
    wr(dpc_pkg::LOAD0_OFS, 32'h9, dpc_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(dpc_pkg::LOAD0_OFS, 32'h4, dpc_pkg::RESP_OKAY);
    $display("test commands done");
    wr(dpc_pkg::PINCFG_OFS, 32'hf, dpc_pkg::RESP_OKAY);
    wr(dpc_pkg::LOAD1_OFS, 32'h3, dpc_pkg::RESP_OKAY);
    wr(dpc_pkg::PRE1_OFS, 32'h0, dpc_pkg::RESP_OKAY);
    @(negedge aclk);
    p = counter_output_pin;
    wr(dpc_pkg::CTRL1_OFS, 32'h1, dpc_pkg::RESP_OKAY);
    u_dpc_pin_src.pulses(2);
    repeat (10) @(posedge aclk);
    check(32'(second_timer_request), 32'h0);
    u_dpc_pin_src.pulses(1);
    wait_req(1'b1, n);
    check(32'(n <= 8), 32'h1);
    check(32'(irq), 32'h0);
    repeat (3) @(posedge aclk);
    check(32'(counter_output_pin), 32'(!p));
    rd(dpc_pkg::IRQ_STAT_OFS, 32'h2, dpc_pkg::RESP_OKAY);
    $display("test external input done");
    end_of_test();
  end
endmodule
`default_nettype wire
